// ==== hw/cpcs_pkg.sv ====
// cpcs_pkg: constants and carrier types for the crtc protect / clock select block.
// assumes host strobes are single-cycle pulses produced on ref_clk_i.
package cpcs_pkg;

	// host i/o addresses (10-bit isa decode)
	localparam logic [9:0] ATTR_ADDR_PORT = 10'h3c0;
	localparam logic [9:0] ATTR_READ_PORT = 10'h3c1;
	localparam logic [9:0] GFX_INDEX_PORT = 10'h3ce;
	localparam logic [9:0] GFX_DATA_PORT = 10'h3cf;
	localparam logic [9:0] CRTC_INDEX_COLOR = 10'h3d4;
	localparam logic [9:0] CRTC_DATA_COLOR = 10'h3d5;
	localparam logic [9:0] STATUS_COLOR = 10'h3da;
	localparam logic [9:0] CRTC_INDEX_MONO = 10'h3b4;
	localparam logic [9:0] CRTC_DATA_MONO = 10'h3b5;
	localparam logic [9:0] STATUS_MONO = 10'h3ba;

	// extension indices behind the graphics data port
	localparam logic [7:0] CRTC_WRITE_GUARD_IDX = 8'h83;
	localparam logic [7:0] VIDEO_CLOCK_CHOICE_IDX = 8'h84;

	// crtc_write_guard fields
	localparam int GUARD_PALETTE_BIT = 6;
	localparam int GUARD_TOTAL_BIT = 4;
	localparam int GUARD_BLANK_BIT = 3;
	localparam int GUARD_VDE_BIT = 2;
	localparam int GUARD_TIMING_BIT = 1;
	localparam int GUARD_VERT_BIT = 0;
	localparam logic [7:0] GUARD_RESET = 8'h00;
	localparam logic [7:0] GUARD_WRITE_MASK = 8'h5f;

	// video_clock_choice fields
	localparam int CLOCK_SOURCE_BIT = 7;
	localparam int CLOCK_CODE_HI = 5;
	localparam int CLOCK_CODE_LO = 2;
	localparam int CLOCK_HALVE_BIT = 1;
	localparam logic [7:0] CLOCK_CHOICE_RESET = 8'h20;
	localparam logic [7:0] CLOCK_CHOICE_WRITE_MASK = 8'hbe;

	// general output register fields
	localparam int MISC_COLOR_BIT = 0;
	localparam int MISC_CLOCK_HI = 3;
	localparam int MISC_CLOCK_LO = 2;

	// crtc register file geometry
	localparam int CRTC_COUNT = 25;
	localparam logic [7:0] CRTC_RESET = 8'h00;
	localparam int PALETTE_COUNT = 16;
	localparam logic [7:0] PALETTE_RESET = 8'h00;
	localparam logic [7:0] ATTR_INDEX_MASK = 8'h1f;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [9:0] addr;
		logic [7:0] wdata;
	} cpcs_io_req_t;

	// load of one working-set register by the extension crtc logic
	typedef struct packed {
		logic valid;
		logic [7:0] index;
		logic [7:0] data;
	} cpcs_ws_load_t;

	typedef struct packed {
		logic [3:0] code;
		logic halve;
	} cpcs_clock_sel_t;

endpackage

// ==== hw/cpcs_clock_choice.sv ====
// cpcs_clock_choice: video_clock_choice register and the synthesizer select code.
// assumes misc_out_i is the general output register on the same clock.
`timescale 1ns/1ps
module cpcs_clock_choice
	import cpcs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] misc_out_i,
	output logic [7:0] choice_o,
	output cpcs_clock_sel_t clock_sel_o
);

	logic [7:0] choice_q;
	cpcs_clock_sel_t sel_q;
	cpcs_clock_sel_t sel_d;

	// reserved bits never stored, so they read zero
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			choice_q <= CLOCK_CHOICE_RESET;
		end else if (wr_i) begin
			choice_q <= wdata_i & CLOCK_CHOICE_WRITE_MASK;
		end
	end

	always_comb begin
		if (choice_q[CLOCK_SOURCE_BIT]) begin
			sel_d.code = choice_q[CLOCK_CODE_HI:CLOCK_CODE_LO];
		end else begin
			sel_d.code = {choice_q[CLOCK_CODE_HI:CLOCK_CODE_HI-1],
				misc_out_i[MISC_CLOCK_HI:MISC_CLOCK_LO]};
		end
		sel_d.halve = choice_q[CLOCK_HALVE_BIT];
	end

	// registered so the synthesizer sees one clean code change
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			sel_q <= '0;
		end else begin
			sel_q <= sel_d;
		end
	end

	assign choice_o = choice_q;
	assign clock_sel_o = sel_q;

endmodule

// ==== hw/cpcs_regs.sv ====
// cpcs_regs: indexed extension registers guarding crtc timing and the palette,
// plus the standard crtc and attribute palette paths they govern.
// assumes one host access per pulse, strobes synchronous to ref_clk_i.
//
// Notes on behaviour
// - guard and clock-choice registers sit at graphics data port indices 83 and 84.
// - bit 4 hands total/retrace group to working set; standard copies turn read-only.
// - unguarded bits: standard registers drive timing, host writes also fill working set.
// - bit 3 does the same for the blanking group.
// - bit 2 does the same for the vertical display end group.
// - bit 1 does the same for the display timing group.
// - bit 0 does the same for the vertical parameter group.
// - clock source bit set: all four code bits from choice bits 5:2.
// - clock source clear: upper code from choice 5:4, lower from misc 3:2.
// - halve bit asks the synthesizer for a further divide by two.
`timescale 1ns/1ps
module cpcs_regs
	import cpcs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input cpcs_io_req_t io_req_i,
	input wire logic [7:0] misc_out_i,
	input cpcs_ws_load_t ws_load_i,
	output logic [7:0] io_rdata_o,
	output logic io_rvalid_o,
	output logic [CRTC_COUNT-1:0][7:0] crtc_timing_o,
	output logic [PALETTE_COUNT-1:0][7:0] palette_entries_o,
	output logic [7:0] crtc_write_guard_o,
	output cpcs_clock_sel_t clock_sel_o
);

	// bits of one crtc register taken over by the asserted guard bits
	function automatic logic [7:0] guard_mask(input logic [7:0] idx, input logic [7:0] guard);
		logic [7:0] m;
		m = 8'h00;
		if (guard[GUARD_TOTAL_BIT]) begin
			case (idx)
				8'h00, 8'h04, 8'h06, 8'h10, 8'h11: m = m | 8'hff;
				8'h05: m = m | 8'h1f;
				8'h07: m = m | 8'ha5;
				default: m = m;
			endcase
		end
		if (guard[GUARD_BLANK_BIT]) begin
			case (idx)
				8'h02, 8'h15, 8'h16: m = m | 8'hff;
				8'h03: m = m | 8'h1f;
				8'h05: m = m | 8'h80;
				8'h07: m = m | 8'h08;
				8'h09: m = m | 8'h20;
				default: m = m;
			endcase
		end
		if (guard[GUARD_VDE_BIT]) begin
			case (idx)
				8'h12: m = m | 8'hff;
				8'h07: m = m | 8'h42;
				default: m = m;
			endcase
		end
		if (guard[GUARD_TIMING_BIT]) begin
			case (idx)
				8'h09, 8'h0a, 8'h0b, 8'h12, 8'h14: m = m | 8'hff;
				8'h07: m = m | 8'h42;
				default: m = m;
			endcase
		end
		if (guard[GUARD_VERT_BIT]) begin
			case (idx)
				8'h06, 8'h10, 8'h15, 8'h16: m = m | 8'hff;
				8'h07: m = m | 8'had;
				8'h09: m = m | 8'h20;
				8'h11: m = m | 8'h0f;
				default: m = m;
			endcase
		end
		return m;
	endfunction

	logic [7:0] gfx_index_q;
	logic [7:0] crtc_index_q;
	logic [7:0] attr_index_q;
	logic attr_data_phase_q;
	logic [7:0] guard_q;
	logic [CRTC_COUNT-1:0][7:0] std_q;
	logic [CRTC_COUNT-1:0][7:0] work_q;
	logic [CRTC_COUNT-1:0][7:0] timing_q;
	logic [PALETTE_COUNT-1:0][7:0] palette_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic [7:0] clock_choice;
	logic color_base;
	logic crtc_index_hit;
	logic crtc_data_hit;
	logic status_hit;
	logic crtc_idx_ok;
	logic [7:0] wr_mask;
	logic guard_wr;
	logic clock_wr;
	logic attr_wr;
	logic [7:0] rdata_d;

	// port decode follows the mono/colour base chosen by the general output register
	always_comb begin
		color_base = misc_out_i[MISC_COLOR_BIT];
		crtc_index_hit = io_req_i.addr == (color_base ? CRTC_INDEX_COLOR : CRTC_INDEX_MONO);
		crtc_data_hit = io_req_i.addr == (color_base ? CRTC_DATA_COLOR : CRTC_DATA_MONO);
		status_hit = io_req_i.addr == (color_base ? STATUS_COLOR : STATUS_MONO);
		crtc_idx_ok = crtc_index_q < 8'(CRTC_COUNT);
		wr_mask = guard_mask(crtc_index_q, guard_q);
		guard_wr = io_req_i.wr && io_req_i.addr == GFX_DATA_PORT
			&& gfx_index_q == CRTC_WRITE_GUARD_IDX;
		clock_wr = io_req_i.wr && io_req_i.addr == GFX_DATA_PORT
			&& gfx_index_q == VIDEO_CLOCK_CHOICE_IDX;
		attr_wr = io_req_i.wr && io_req_i.addr == ATTR_ADDR_PORT && attr_data_phase_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			gfx_index_q <= 8'h00;
			crtc_index_q <= 8'h00;
		end else if (io_req_i.wr) begin
			if (io_req_i.addr == GFX_INDEX_PORT) begin
				gfx_index_q <= io_req_i.wdata;
			end
			if (crtc_index_hit) begin
				crtc_index_q <= io_req_i.wdata;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			guard_q <= GUARD_RESET;
		end else if (guard_wr) begin
			guard_q <= io_req_i.wdata & GUARD_WRITE_MASK;
		end
	end

	// standard copies: guarded bits keep their value, so they read back unchanged
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			std_q <= '{default: CRTC_RESET};
		end else if (io_req_i.wr && crtc_data_hit && crtc_idx_ok) begin
			std_q[crtc_index_q[4:0]] <= (std_q[crtc_index_q[4:0]] & wr_mask)
				| (io_req_i.wdata & ~wr_mask);
		end
	end

	// working set: host writes mirror in for unguarded bits; extension loads win
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			work_q <= '{default: CRTC_RESET};
		end else if (ws_load_i.valid && ws_load_i.index < 8'(CRTC_COUNT)) begin
			work_q[ws_load_i.index[4:0]] <= ws_load_i.data;
		end else if (io_req_i.wr && crtc_data_hit && crtc_idx_ok) begin
			work_q[crtc_index_q[4:0]] <= (work_q[crtc_index_q[4:0]] & wr_mask)
				| (io_req_i.wdata & ~wr_mask);
		end
	end

	// per bit, the guard decides which copy drives the timing logic
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			timing_q <= '{default: CRTC_RESET};
		end else begin
			for (int i = 0; i < CRTC_COUNT; i++) begin
				timing_q[i] <= (std_q[i] & ~guard_mask(8'(i), guard_q))
					| (work_q[i] & guard_mask(8'(i), guard_q));
			end
		end
	end

	// attribute port toggles index/data; a status read rearms the index phase
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			attr_index_q <= 8'h00;
			attr_data_phase_q <= 1'b0;
		end else if (io_req_i.rd && status_hit) begin
			attr_data_phase_q <= 1'b0;
		end else if (io_req_i.wr && io_req_i.addr == ATTR_ADDR_PORT) begin
			if (!attr_data_phase_q) begin
				attr_index_q <= io_req_i.wdata & ATTR_INDEX_MASK;
			end
			attr_data_phase_q <= !attr_data_phase_q;
		end
	end

	// the data phase still toggles when guarded, so the host stays in step
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			palette_q <= '{default: PALETTE_RESET};
		end else if (attr_wr && attr_index_q < 8'(PALETTE_COUNT)
			&& !guard_q[GUARD_PALETTE_BIT]) begin
			palette_q[attr_index_q[3:0]] <= io_req_i.wdata;
		end
	end

	cpcs_clock_choice u_clock_choice (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.wr_i(clock_wr),
		.wdata_i(io_req_i.wdata),
		.misc_out_i(misc_out_i),
		.choice_o(clock_choice),
		.clock_sel_o(clock_sel_o)
	);

	// unmapped ports and indices read zero
	always_comb begin
		rdata_d = 8'h00;
		if (io_req_i.addr == GFX_INDEX_PORT) begin
			rdata_d = gfx_index_q;
		end else if (io_req_i.addr == GFX_DATA_PORT) begin
			if (gfx_index_q == CRTC_WRITE_GUARD_IDX) begin
				rdata_d = guard_q;
			end else if (gfx_index_q == VIDEO_CLOCK_CHOICE_IDX) begin
				rdata_d = clock_choice;
			end
		end else if (crtc_index_hit) begin
			rdata_d = crtc_index_q;
		end else if (crtc_data_hit && crtc_idx_ok) begin
			rdata_d = std_q[crtc_index_q[4:0]];
		end else if (io_req_i.addr == ATTR_ADDR_PORT) begin
			rdata_d = attr_index_q;
		end else if (io_req_i.addr == ATTR_READ_PORT && attr_index_q < 8'(PALETTE_COUNT)) begin
			rdata_d = palette_q[attr_index_q[3:0]];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= io_req_i.rd;
			if (io_req_i.rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign io_rdata_o = rdata_q;
	assign io_rvalid_o = rvalid_q;
	assign crtc_timing_o = timing_q;
	assign palette_entries_o = palette_q;
	assign crtc_write_guard_o = guard_q;

endmodule

// ==== verification/cpcs_regs_props.sv ====
// cpcs_regs_props: port-level assertions for the guard and clock choice block.
// assumes it is bound to cpcs_regs; the graphics index is shadowed here.
`timescale 1ns/1ps
module cpcs_regs_props
	import cpcs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input cpcs_io_req_t io_req_i,
	input cpcs_ws_load_t ws_load_i,
	input wire logic io_rvalid_o,
	input wire logic [CRTC_COUNT-1:0][7:0] crtc_timing_o,
	input wire logic [PALETTE_COUNT-1:0][7:0] palette_entries_o,
	input wire logic [7:0] crtc_write_guard_o,
	input cpcs_clock_sel_t clock_sel_o
);
	logic [7:0] gidx_q;
	logic gw;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			gidx_q <= 8'h00;
		end else if (io_req_i.wr && io_req_i.addr == GFX_INDEX_PORT) begin
			gidx_q <= io_req_i.wdata;
		end
	end
	assign gw = io_req_i.wr && io_req_i.addr == GFX_DATA_PORT;
	// three quiet cycles so an in-flight write has landed first
	property frozen(int b, int r);
		(crtc_write_guard_o[b] && !ws_load_i.valid) [*3] |-> $stable(crtc_timing_o[r]);
	endproperty
	read_answer_a: assert property (io_req_i.rd |=> io_rvalid_o)
		else $error("read not answered next cycle");
	rvalid_cause_a: assert property (io_rvalid_o |-> $past(io_req_i.rd))
		else $error("read valid without a read");
	guard_write_a: assert property (gw && gidx_q == CRTC_WRITE_GUARD_IDX |=>
		crtc_write_guard_o == ($past(io_req_i.wdata) & GUARD_WRITE_MASK))
		else $error("guard register write wrong");
	clock_upper_a: assert property (gw && gidx_q == VIDEO_CLOCK_CHOICE_IDX |-> ##2
		clock_sel_o.code[3:2] == $past(io_req_i.wdata[5:4], 2)
		&& clock_sel_o.halve == $past(io_req_i.wdata[1], 2))
		else $error("clock code upper or halve wrong");
	clock_lower_a: assert property (gw && gidx_q == VIDEO_CLOCK_CHOICE_IDX
		&& io_req_i.wdata[7] |-> ##2 clock_sel_o.code[1:0] == $past(io_req_i.wdata[3:2], 2))
		else $error("clock code lower wrong");
	palette_hold_a: assert property (crtc_write_guard_o[GUARD_PALETTE_BIT] [*3]
		|-> $stable(palette_entries_o))
		else $error("palette changed while guarded");
	total_hold_a: assert property (frozen(4, 0))
		else $error("total group changed while guarded");
	blank_hold_a: assert property (frozen(3, 2))
		else $error("blank group changed while guarded");
	vde_hold_a: assert property (frozen(2, 18))
		else $error("display end changed while guarded");
	timing_hold_a: assert property (frozen(1, 10))
		else $error("display timing changed while guarded");
	vert_hold_a: assert property (frozen(0, 16))
		else $error("vertical group changed while guarded");
	cover property (gw && gidx_q == CRTC_WRITE_GUARD_IDX);
	cover property (gw && gidx_q == VIDEO_CLOCK_CHOICE_IDX && io_req_i.wdata[7]);
	cover property (ws_load_i.valid && crtc_write_guard_o[GUARD_TOTAL_BIT]);
endmodule

bind cpcs_regs cpcs_regs_props u_props (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.io_req_i(io_req_i), .ws_load_i(ws_load_i), .io_rvalid_o(io_rvalid_o),
	.crtc_timing_o(crtc_timing_o), .palette_entries_o(palette_entries_o),
	.crtc_write_guard_o(crtc_write_guard_o), .clock_sel_o(clock_sel_o));

// ==== verification/cpcs_host.sv ====
// cpcs_host: host processor model issuing isa i/o cycles.
// assumes the bench calls its tasks; strobes launched at falling edges.
`timescale 1ns/1ps
module cpcs_host
	import cpcs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [7:0] io_rdata_i,
	input wire logic io_rvalid_i,
	output cpcs_io_req_t io_req_o
);
	initial io_req_o = '0;
	// released lines show the inverse, so stale data never looks valid
	task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		io_req_o = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge ref_clk_i);
		io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		acc(1'b0, a, 8'h00);
		d = io_rvalid_i ? io_rdata_i : 8'hxx;
	endtask
	// index always written before its data
	task automatic xw(input logic [9:0] p, input logic [7:0] i, input logic [7:0] d);
		acc(1'b1, p, i);
		acc(1'b1, p + 10'h001, d);
	endtask
	task automatic xr(input logic [9:0] p, input logic [7:0] i, output logic [7:0] d);
		acc(1'b1, p, i);
		rd(p + 10'h001, d);
	endtask
endmodule

// ==== verification/tb.sv ====
// tb: self-checking bench for cpcs_regs.
// assumes the host model owns io_req_i; misc and working-set loads driven here.
`timescale 1ns/1ps
module tb
	import cpcs_pkg::*;
;
	logic ref_clk_i, reset_n_i, rvalid;
	cpcs_io_req_t io_req;
	cpcs_ws_load_t ws;
	cpcs_clock_sel_t csel;
	logic [7:0] misc, rdata, v, guard;
	logic [CRTC_COUNT-1:0][7:0] timing;
	logic [PALETTE_COUNT-1:0][7:0] pal;
	int err_count, checks, cyc;
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	cpcs_host host (.ref_clk_i(ref_clk_i), .io_rdata_i(rdata), .io_rvalid_i(rvalid),
		.io_req_o(io_req));
	cpcs_regs dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .io_req_i(io_req),
		.misc_out_i(misc), .ws_load_i(ws), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
		.crtc_timing_o(timing), .palette_entries_o(pal), .crtc_write_guard_o(guard),
		.clock_sel_o(csel));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic settle();
		repeat (2) @(negedge ref_clk_i);
	endtask
	task automatic wg(input logic [7:0] i, input logic [7:0] d);
		host.xw(GFX_INDEX_PORT, i, d);
	endtask
	task automatic rg(input logic [7:0] i, input logic [7:0] e);
		host.xr(GFX_INDEX_PORT, i, v);
		chk(v, e);
	endtask
	task automatic t_clock();
		chk({4'h0, csel.code}, 8'h0b);
		rg(VIDEO_CLOCK_CHOICE_IDX, CLOCK_CHOICE_RESET);
		wg(VIDEO_CLOCK_CHOICE_IDX, 8'hff);
		settle();
		chk({3'h0, csel}, 8'h1f);
		rg(VIDEO_CLOCK_CHOICE_IDX, 8'hbe);
		wg(VIDEO_CLOCK_CHOICE_IDX, 8'h14);
		settle();
		chk({3'h0, csel}, 8'h0e);
		misc = 8'h05;
		settle();
		chk({4'h0, csel.code}, 8'h05);
		rg(8'h85, 8'h00);
		$display("test clock done");
	endtask
	task automatic t_crtc();
		int b[5] = '{4, 3, 2, 1, 0};
		int r[5] = '{0, 2, 18, 10, 16};
		rg(CRTC_WRITE_GUARD_IDX, GUARD_RESET);
		wg(CRTC_WRITE_GUARD_IDX, 8'hff);
		rg(CRTC_WRITE_GUARD_IDX, 8'h5f);
		chk(guard, 8'h5f);
		for (int i = 0; i < 5; i++) begin
			wg(CRTC_WRITE_GUARD_IDX, 8'h00);
			host.xw(CRTC_INDEX_COLOR, r[i][7:0], 8'h3c);
			settle();
			chk(timing[r[i]], 8'h3c);
			wg(CRTC_WRITE_GUARD_IDX, 8'h01 << b[i]);
			host.xw(CRTC_INDEX_COLOR, r[i][7:0], 8'hc3);
			settle();
			chk(timing[r[i]], 8'h3c);
		end
		wg(CRTC_WRITE_GUARD_IDX, 8'h10);
		ws = '{valid: 1'b1, index: 8'h00, data: 8'h5a};
		@(negedge ref_clk_i);
		ws.valid = 1'b0;
		settle();
		chk(timing[0], 8'h5a);
		// out-of-range load aliases index 0 if the range test is lost
		ws = '{valid: 1'b1, index: 8'h20, data: 8'ha5};
		@(negedge ref_clk_i);
		ws.valid = 1'b0;
		settle();
		chk(timing[0], 8'h5a);
		host.xr(CRTC_INDEX_COLOR, 8'h00, v);
		chk(v, 8'h3c);
		wg(CRTC_WRITE_GUARD_IDX, 8'h00);
		settle();
		chk(timing[0], 8'h3c);
		// mono base: only 3b4/3b5 reach the crtc, the colour pair is dropped
		misc = 8'h04;
		host.xw(CRTC_INDEX_MONO, 8'h01, 8'h77);
		host.xw(CRTC_INDEX_COLOR, 8'h01, 8'h11);
		settle();
		chk(timing[1], 8'h77);
		misc = 8'h05;
		$display("test crtc done");
	endtask
	task automatic t_pal();
		for (int g = 0; g < 2; g++) begin
			wg(CRTC_WRITE_GUARD_IDX, g ? 8'h40 : 8'h00);
			host.rd(STATUS_COLOR, v);
			host.acc(1'b1, ATTR_ADDR_PORT, 8'h05);
			host.acc(1'b1, ATTR_ADDR_PORT, g ? 8'h15 : 8'h2a);
			settle();
			chk(pal[5], 8'h2a);
		end
		$display("test palette done");
	endtask
	initial begin
		reset_n_i = 1'b0;
		misc = 8'h0d;
		ws = '0;
		repeat (3) @(negedge ref_clk_i);
		reset_n_i = 1'b1;
		settle();
		t_clock();
		t_crtc();
		t_pal();
		tally_and_finish();
	end
	// generous ceiling: the run needs well under a thousand cycles
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
endmodule
